// >>> clock_timer.sv
/*
 clock_timer: 8-bit binary clock timer with tap events, reached over APB.
 Assumes APB master on CLOCK, synchronous inputs, byte address = 4 * index.
*/
// Chosen here: register access over APB.
// How it works
// (R1) 8-bit counter steps on 256 Hz tick
// (R2) clock gate bit passes or stops tick
// (R3) run bit starts or stops counting
// (R4) stopped counter holds, resumes from held
// (R5) writing clear bit zeroes the counter
// (R6) clear bit always reads zero
// (R7) count bits read-only, writes ignored
// (R8) low nibble read latches high nibble
// (R9) software reads low before high
// (R10) software double-reads or stops timer
// (R11) eight mask bits, one per tap
// (R12) tap falling edge sets its flag
// (R13) writing one clears a flag
// (R14) flag plus enable keeps requesting interrupt
// (R15) reset zeroes control, masks, flags, count
// (R16) request output when flag and mask
`timescale 1ns/1ps
`default_nettype none

module clock_timer
   import clock_timer_pkg::*;
#(
   parameter int TICK_DIV = TICK_CYCLES
)
(
   input  wire logic        CLOCK,
   input  wire logic        RST_N,
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [17:0] PADDR,
   input  wire logic [31:0] PWDATA,
   output logic [31:0]      PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   output logic             TAP_IRQ
);

   apb_req_t req;

   logic       clock_gate_q;
   logic       clock_gate_d;
   logic       timer_run_q;
   logic       timer_run_d;
   logic [7:0] count_bits_q;
   logic [7:0] count_bits_d;
   logic [3:0] high_latch_q;
   logic [3:0] high_latch_d;
   logic [7:0] tap_mask_bits_q;
   logic [7:0] tap_mask_bits_d;
   logic [7:0] tap_event_flags_q;
   logic [7:0] tap_event_flags_d;
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;
   logic       tick;
   logic       access;
   logic       wr;
   logic       rd_setup;
   logic [15:0] idx;
   logic       mapped;
   logic [3:0] wnib;
   logic [7:0] fall;
   logic [7:0] count_next;

   // pack bus request
   assign req = '{sel: PSEL, enable: PENABLE, write: PWRITE,
                  addr: PADDR, wdata: PWDATA};

   // index decode: byte address is four times index
   function automatic logic [15:0] to_index(input logic [17:0] a);
      return a[17:2];
   endfunction

   function automatic logic is_mapped(input logic [15:0] i);
      return (i == IDX_CLOCK_GATE) || (i == IDX_RUN_CTRL) ||
             (i == IDX_COUNT_LOW)  || (i == IDX_COUNT_HIGH) ||
             (i == IDX_MASK_FAST)  || (i == IDX_MASK_SLOW) ||
             (i == IDX_FLAGS_FAST) || (i == IDX_FLAGS_SLOW);
   endfunction

   // apb access phase, zero wait states
   assign access  = req.sel && req.enable;
   assign idx     = to_index(req.addr);
   assign mapped  = is_mapped(idx);
   assign wr      = access && req.write;
   // reads are decoded in the setup cycle so the data stands at the ready edge
   assign rd_setup = req.sel && !req.enable && !req.write;
   assign wnib    = req.wdata[3:0];
   assign PREADY  = 1'b1;
   assign PSLVERR = access && !mapped;
   assign PRDATA  = rdata_q;

   // 256 Hz tick only while gate and run are both set
   tick_divider #(
      .DIVISOR (TICK_DIV)
   ) u_div (
      .clk   (CLOCK),
      .rst_n (RST_N),
      .run   (clock_gate_q && timer_run_q),   // (R2)
      .tick  (tick)
   );

   // control and mask registers
   always_comb
   begin
      clock_gate_d    = clock_gate_q;
      timer_run_d     = timer_run_q;
      tap_mask_bits_d = tap_mask_bits_q;
      if (wr && idx == IDX_CLOCK_GATE)
         clock_gate_d = wnib[GATE_BIT];                        // (R2)
      if (wr && idx == IDX_RUN_CTRL)
         timer_run_d = wnib[RUN_BIT];                          // (R3)
      if (wr && idx == IDX_MASK_FAST)
         tap_mask_bits_d[3:0] = wnib;                          // (R11)
      if (wr && idx == IDX_MASK_SLOW)
         tap_mask_bits_d[7:4] = wnib;                          // (R11)
   end

   // counter: count on tick, hold when stopped, clear on request
   always_comb
   begin
      count_next   = count_bits_q + 8'h01;
      count_bits_d = count_bits_q;                             // (R4)
      if (tick)
         count_bits_d = count_next;                            // (R1)
      if (wr && idx == IDX_RUN_CTRL && wnib[CLEAR_BIT])
         count_bits_d = COUNT_RESET;                           // (R5)
      // count bit writes have no effect (R7)
   end

   // tap falling edges: bit goes 1 to 0 on this step
   assign fall = count_bits_q & ~count_bits_d;

   // event flags: set wins over write-one clear
   always_comb
   begin
      tap_event_flags_d = tap_event_flags_q;
      if (wr && idx == IDX_FLAGS_FAST)
         tap_event_flags_d[3:0] = tap_event_flags_q[3:0] & ~wnib;  // (R13)
      if (wr && idx == IDX_FLAGS_SLOW)
         tap_event_flags_d[7:4] = tap_event_flags_q[7:4] & ~wnib;  // (R13)
      tap_event_flags_d = tap_event_flags_d | fall;               // (R12)
   end

   // read data and high nibble snapshot taken together at the setup edge,
   // so low and high halves come from one counter value
   always_comb
   begin
      high_latch_d = high_latch_q;
      rdata_d      = 32'h00000000;
      if (rd_setup)
      begin
         unique case (idx)
            IDX_CLOCK_GATE:
               rdata_d[GATE_BIT] = clock_gate_q;
            IDX_RUN_CTRL:
               rdata_d[RUN_BIT] = timer_run_q;   // clear bit reads 0 (R6)
            IDX_COUNT_LOW:
            begin
               rdata_d[3:0] = count_bits_q[3:0];
               high_latch_d = count_bits_q[7:4];                 // (R8)
            end
            IDX_COUNT_HIGH:
               rdata_d[3:0] = high_latch_q;                      // (R8)
            IDX_MASK_FAST:
               rdata_d[3:0] = tap_mask_bits_q[3:0];
            IDX_MASK_SLOW:
               rdata_d[3:0] = tap_mask_bits_q[7:4];
            IDX_FLAGS_FAST:
               rdata_d[3:0] = tap_event_flags_q[3:0];
            IDX_FLAGS_SLOW:
               rdata_d[3:0] = tap_event_flags_q[7:4];
            default:
               rdata_d = 32'h00000000;
         endcase
      end
   end

   // register all state
   always_ff @(posedge CLOCK)
   begin
      if (!RST_N)
      begin
         clock_gate_q      <= 1'b0;                              // (R15)
         timer_run_q       <= 1'b0;
         count_bits_q      <= COUNT_RESET;
         high_latch_q      <= 4'h0;
         tap_mask_bits_q   <= MASK_RESET;
         tap_event_flags_q <= FLAG_RESET;
         rdata_q           <= 32'h00000000;
      end
      else
      begin
         clock_gate_q      <= clock_gate_d;
         timer_run_q       <= timer_run_d;
         count_bits_q      <= count_bits_d;
         high_latch_q      <= high_latch_d;
         tap_mask_bits_q   <= tap_mask_bits_d;
         tap_event_flags_q <= tap_event_flags_d;
         rdata_q           <= rdata_d;
      end
   end

   // request stays high while any enabled flag is set
   assign TAP_IRQ = |(tap_event_flags_q & tap_mask_bits_q);     // (R14) (R16)

endmodule // clock_timer

`default_nettype wire

// >>> clock_timer_bench.sv
/* clock_timer_bench: apb register tests of clock_timer.
   Assumes TICK_DIV of 4 and read data valid at the ready edge. */
`timescale 1ns/1ps
`default_nettype none
module clock_timer_bench
   import clock_timer_pkg::*;
;
   logic        clock = 1'b0;
   logic        rst_n = 1'b0;
   apb_req_t    req = '0;
   logic [31:0] prdata, got;
   logic        pready, pslverr, irq, err;
   logic [3:0]  lo, hi;
   int          n_fail = 0, checked = 0, cyc = 0;
   logic [15:0] regs [9] = '{IDX_CLOCK_GATE, IDX_RUN_CTRL, IDX_COUNT_LOW,
      IDX_COUNT_HIGH, IDX_MASK_FAST, IDX_MASK_SLOW, IDX_FLAGS_FAST,
      IDX_FLAGS_SLOW, 16'h0123};
   always #4 clock = ~clock;
   clock_timer #(.TICK_DIV(4)) u_clock_timer (.CLOCK(clock), .RST_N(rst_n),
      .PSEL(req.sel), .PENABLE(req.enable), .PWRITE(req.write),
      .PADDR(req.addr), .PWDATA(req.wdata), .PRDATA(prdata),
      .PREADY(pready), .PSLVERR(pslverr), .TAP_IRQ(irq));
   task automatic stop_test();
      $display("mismatches %0d compares %0d", n_fail, checked);
      if (n_fail == 0 && checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // cycle ceiling cuts a hang short
   always @(posedge clock)
   begin
      cyc <= cyc + 1;
      if (cyc == 3000)
      begin
         n_fail++;
         stop_test();
      end
   end
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // one apb transfer, left in access state; data and error taken at ready
   task automatic xfer(input logic w, input logic [15:0] i,
                       input logic [3:0] d);
      req <= '{1'b1, 1'b0, w, {i, 2'b00}, {28'h0, d}};
      @(posedge clock);
      req.enable <= 1'b1;
      do
         @(posedge clock);
      while (pready !== 1'b1);
      got = prdata;
      err = pslverr;
   endtask
   task automatic idle();
      req <= '0;
      @(posedge clock);
   endtask
   task automatic rd(input logic [15:0] i);
      xfer(1'b0, i, 4'h0);
      idle();
   endtask
   task automatic wr_rd(input logic [15:0] i, input logic [3:0] d);
      xfer(1'b1, i, d);
      rd(i);
   endtask
   // main sequence
   initial
   begin
      repeat (10) @(posedge clock);
      rst_n <= 1'b1;
      foreach (regs[i])
      begin
         rd(regs[i]);
         chk(got[7:0], 8'h00);
      end
      chk({7'h0, err}, 8'h01);
      $display("test reset done");
      wr_rd(IDX_MASK_FAST, 4'ha); chk(got[7:0], 8'h0a);
      wr_rd(IDX_MASK_SLOW, 4'h5); chk(got[7:0], 8'h05);
      wr_rd(IDX_CLOCK_GATE, 4'h1); chk(got[7:0], 8'h01);
      wr_rd(IDX_RUN_CTRL, 4'h2); chk(got[7:0], 8'h00);
      $display("test readback done");
      wr_rd(IDX_RUN_CTRL, 4'h1); chk(got[7:0], 8'h01);
      repeat (40) @(posedge clock);
      xfer(1'b1, IDX_RUN_CTRL, 4'h0);
      rd(IDX_COUNT_LOW); lo = got[3:0];
      rd(IDX_COUNT_HIGH); hi = got[3:0];
      chk(8'({hi, lo} >= 10 && {hi, lo} <= 12), 8'h01);
      repeat (20) @(posedge clock);
      xfer(1'b1, IDX_COUNT_LOW, ~lo); chk({7'h0, err}, 8'h00);
      rd(IDX_COUNT_LOW); chk(got[7:0], {4'h0, lo});
      rd(IDX_COUNT_HIGH); chk(got[7:0], {4'h0, hi});
      $display("test count done");
      xfer(1'b1, IDX_RUN_CTRL, 4'h3);
      rd(IDX_COUNT_LOW);
      repeat (100) @(posedge clock);
      rd(IDX_COUNT_HIGH); chk(got[7:0], 8'h00);
      xfer(1'b1, IDX_RUN_CTRL, 4'h0);
      rd(IDX_COUNT_LOW);
      xfer(1'b0, IDX_COUNT_HIGH, 4'h0); chk(got[7:0], 8'h01);
      rd(IDX_COUNT_HIGH); chk(got[7:0], 8'h01);
      $display("test latch done");
      rd(IDX_FLAGS_FAST); chk(got[7:0], 8'h0f);
      rd(IDX_FLAGS_SLOW); chk(got[7:0], 8'h00);
      chk({7'h0, irq}, 8'h01);
      xfer(1'b1, IDX_FLAGS_FAST, 4'h0); idle();
      chk({7'h0, irq}, 8'h01);
      wr_rd(IDX_FLAGS_FAST, 4'h5); chk(got[7:0], 8'h0a);
      chk({7'h0, irq}, 8'h01);
      xfer(1'b1, IDX_MASK_FAST, 4'h0); idle();
      chk({7'h0, irq}, 8'h00);
      wr_rd(IDX_FLAGS_FAST, 4'ha); chk(got[7:0], 8'h00);
      $display("test flags done");
      stop_test();
   end
endmodule // clock_timer_bench
`default_nettype wire

// >>> clock_timer_checker.sv
/* clock_timer_checker: port assertions for clock_timer.
   Assumes read data registered at the setup edge, valid at the ready edge. */
`timescale 1ns/1ps
`default_nettype none
module clock_timer_checker
   import clock_timer_pkg::*;
(
   input wire logic        CLOCK,
   input wire logic        RST_N,
   input wire logic        PSEL,
   input wire logic        PENABLE,
   input wire logic        PWRITE,
   input wire logic [17:0] PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic [31:0] PRDATA,
   input wire logic        PREADY,
   input wire logic        PSLVERR,
   input wire logic        TAP_IRQ
);
   default clocking @(posedge CLOCK); endclocking
   default disable iff (!RST_N);
   // completed transfer decode
   logic acc;
   assign acc = PSEL && PENABLE && PREADY;
   sequence s_wr(logic [15:0] i);
      acc && PWRITE && PADDR == {i, 2'b00};
   endsequence
   sequence s_rd(logic [15:0] i);
      acc && !PWRITE && PADDR == {i, 2'b00};
   endsequence
   property p_reset_clean;
      $rose(RST_N) |-> !TAP_IRQ && PRDATA == 32'h0;
   endproperty
   a_reset_clean: assert property (p_reset_clean)
      else $error("state not clear after reset");
   // read data stands at the ready edge of the read itself
   property p_clear_reads_zero;
      s_rd(IDX_RUN_CTRL) |-> PRDATA[CLEAR_BIT] == 1'b0;
   endproperty
   a_clear_reads_zero: assert property (p_clear_reads_zero)
      else $error("clear bit read as one");
   property p_gate_back;
      s_wr(IDX_CLOCK_GATE) ##1 PSEL ##1 s_rd(IDX_CLOCK_GATE)
         |-> PRDATA[GATE_BIT] == $past(PWDATA[GATE_BIT], 2);
   endproperty
   a_gate_back: assert property (p_gate_back)
      else $error("gate bit readback wrong");
   property p_run_back;
      s_wr(IDX_RUN_CTRL) ##1 PSEL ##1 s_rd(IDX_RUN_CTRL)
         |-> PRDATA[RUN_BIT] == $past(PWDATA[RUN_BIT], 2);
   endproperty
   a_run_back: assert property (p_run_back)
      else $error("run bit readback wrong");
   property p_mask_back;
      s_wr(IDX_MASK_FAST) ##1 PSEL ##1 s_rd(IDX_MASK_FAST)
         |-> PRDATA[3:0] == $past(PWDATA[3:0], 2);
   endproperty
   a_mask_back: assert property (p_mask_back)
      else $error("mask readback wrong");
   property p_high_latched;
      s_rd(IDX_COUNT_HIGH) ##1 PSEL ##1 s_rd(IDX_COUNT_HIGH)
         |-> PRDATA == $past(PRDATA, 2);
   endproperty
   a_high_latched: assert property (p_high_latched)
      else $error("high nibble changed without low read");
   property p_irq_holds;
      TAP_IRQ && !(acc && PWRITE) |=> TAP_IRQ;
   endproperty
   a_irq_holds: assert property (p_irq_holds)
      else $error("request dropped without a write");
   property p_zero_write_keeps;
      TAP_IRQ && PWDATA[3:0] == 4'h0 ##0 s_wr(IDX_FLAGS_FAST) |=> TAP_IRQ;
   endproperty
   a_zero_write_keeps: assert property (p_zero_write_keeps)
      else $error("writing zero cleared a flag");
endmodule // clock_timer_checker
bind clock_timer clock_timer_checker u_clock_timer_checker (
   .CLOCK(CLOCK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
   .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
   .PREADY(PREADY), .PSLVERR(PSLVERR), .TAP_IRQ(TAP_IRQ));
`default_nettype wire

// >>> clock_timer_pkg.sv
/*
 clock_timer_pkg: register offsets, reset values and count constants for
 the clock timer block.
 Assumes a 125 MHz system clock and APB with 32-bit data.
*/
`default_nettype none

package clock_timer_pkg;

   // printed offsets are not all multiples of four: they are indices
   localparam logic [15:0] IDX_CLOCK_GATE  = 16'hff16;
   localparam logic [15:0] IDX_RUN_CTRL    = 16'hff40;
   localparam logic [15:0] IDX_COUNT_LOW   = 16'hff41;
   localparam logic [15:0] IDX_COUNT_HIGH  = 16'hff42;
   localparam logic [15:0] IDX_MASK_FAST   = 16'hffee;
   localparam logic [15:0] IDX_MASK_SLOW   = 16'hffef;
   localparam logic [15:0] IDX_FLAGS_FAST  = 16'hfffe;
   localparam logic [15:0] IDX_FLAGS_SLOW  = 16'hffff;

   // field positions
   localparam int GATE_BIT  = 0;
   localparam int RUN_BIT   = 0;
   localparam int CLEAR_BIT = 1;

   // reset values
   localparam logic [7:0] COUNT_RESET = 8'h00;
   localparam logic [7:0] MASK_RESET  = 8'h00;
   localparam logic [7:0] FLAG_RESET  = 8'h00;

   // tick timing: crystal 32768 Hz divided by 128 gives 256 Hz
   localparam int CRYSTAL_HZ   = 32768;
   localparam int COUNT_DIV    = 128;
   localparam int COUNT_HZ     = CRYSTAL_HZ / COUNT_DIV;
   localparam int SYS_CLOCK_HZ = 125000000;
   localparam int TICK_CYCLES  = SYS_CLOCK_HZ / COUNT_HZ;

   // apb request carried as one bundle
   typedef struct packed {
      logic        sel;
      logic        enable;
      logic        write;
      logic [17:0] addr;
      logic [31:0] wdata;
   } apb_req_t;

endpackage

`default_nettype wire

// >>> tick_divider.sv
/*
 tick_divider: produces a one-cycle enable pulse every DIVISOR cycles while
 run is high; holds its phase otherwise.
 Assumes a single clock and synchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none

module tick_divider
   import clock_timer_pkg::*;
#(
   parameter int DIVISOR = TICK_CYCLES
)
(
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic run,
   output logic      tick
);

   localparam int CW = $clog2(DIVISOR);
   localparam logic [CW-1:0] LAST = CW'(DIVISOR - 1);

   logic [CW-1:0] cnt_q;
   logic [CW-1:0] cnt_d;

   // next count and pulse
   always_comb
   begin
      cnt_d = cnt_q;
      tick  = 1'b0;
      if (run)
      begin
         if (cnt_q == LAST)
         begin
            cnt_d = '0;
            tick  = 1'b1;
         end
         else
            cnt_d = cnt_q + 1'b1;
      end
   end

   // register
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         cnt_q <= '0;
      else
         cnt_q <= cnt_d;
   end

endmodule // tick_divider

`default_nettype wire
